/* File: hdl/sgcaf_cfg.svh */
// Offsets, field positions, reset values and timing figures of the global control bank
`ifndef SGCAF_CFG_SVH
`define SGCAF_CFG_SVH
`define SGCAF_CLK_HZ 40000000
`define SGCAF_FAST_AGE_US 800
`define SGCAF_NORMAL_AGE_S 300
`define SGCAF_IDX_A 6'h02
`define SGCAF_IDX_B 6'h03
`define SGCAF_RST_A 8'h0c
`define SGCAF_RST_B 8'h04
`define SGCAF_WMASK_A 8'h03
`define SGCAF_WMASK_B 8'h7f
`define SGCAF_A_PURGE 4
`define SGCAF_A_COMPL 1
`define SGCAF_A_LCAGE 0
`define SGCAF_B_BIG 6
`define SGCAF_B_TXDIS 5
`define SGCAF_B_RXDIS 4
`define SGCAF_B_LENCHK 3
`define SGCAF_B_AGE 2
`define SGCAF_B_FAST 1
`define SGCAF_B_BACKOFF 0
`define SGCAF_PAUSE_TYPE 16'h8808
`define SGCAF_PAUSE_DA 48'h0180c2000001
`define SGCAF_LEN_TYPE_LIM 16'h05dc
`define SGCAF_BIG_FRAME_MAX 12'h800
`define SGCAF_STD_FRAME_MAX 12'h600
`define SGCAF_MAC_GROUP_BIT 40
`define SGCAF_STRAP_WAIT 2'h3
`define SGCAF_RESP_OKAY 2'h0
`define SGCAF_RESP_SLVERR 2'h2
`endif

/* File: hdl/sgcaf_global_ctrl.sv */
// Global control bank: static purge, pause filtering, aging timer and frame checks
`include "sgcaf_cfg.svh"
`default_nettype none
module sgcaf_global_ctrl #(
  parameter int NPORTS = 5,
  parameter int DEPTH = 16,
  parameter int TAW = $clog2(DEPTH),
  parameter logic [35:0] NORMAL_AGE_CYC = 36'(64'(`SGCAF_NORMAL_AGE_S) * 64'(`SGCAF_CLK_HZ)),
  parameter logic [35:0] FAST_AGE_CYC = 36'(64'(`SGCAF_FAST_AGE_US) * 64'(`SGCAF_CLK_HZ) / 64'd1000000),
  parameter logic [11:0] STD_FRAME_MAX = `SGCAF_STD_FRAME_MAX
) (
  // Clock, reset, enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // AXI4-Lite write
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Strap pin
  input wire logic strap_pause_dis,
  // Port status
  input wire logic [NPORTS-1:0] link_up,
  input wire logic [NPORTS-1:0] learn_dis,
  input wire logic an_tx_pause,
  input wire logic an_rx_pause,
  // Static table load
  input wire logic tbl_wr_valid,
  output logic tbl_wr_ready,
  input wire logic [TAW-1:0] tbl_wr_addr,
  input wire logic tbl_wr_entry_valid,
  input wire logic [NPORTS-1:0] tbl_wr_ports,
  input wire logic [47:0] tbl_wr_mac,
  // Frame check
  input wire logic frm_valid,
  input wire logic [15:0] frm_type_len,
  input wire logic [47:0] frm_da,
  input wire logic [15:0] frm_payload_len,
  input wire logic [11:0] frm_byte_len,
  input wire logic frm_is_pause,
  output logic frm_done,
  output logic frm_drop,
  // Control outputs
  output logic tx_pause_en,
  output logic rx_pause_en,
  output logic aggr_backoff,
  output logic age_tick,
  output logic age_all
);
  import sgcaf_pkg::*;

  localparam int W = 49 + NPORTS;

  logic [7:0] ctrl_a_reg, ctrl_a_next, ctrl_b_reg, ctrl_b_next;
  logic aw_got_reg, aw_got_next, w_got_reg, w_got_next, w_lane_reg, w_lane_next;
  logic [7:0] aw_addr_reg, aw_addr_next, w_data_reg, w_data_next;
  logic bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
  logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [1:0] strap_cnt_reg, strap_cnt_next;
  logic strap_done_reg, strap_done_next, strap_s1_reg, strap_s2_reg;
  logic wr_fire;
  logic [5:0] wr_idx, rd_idx;

  sgcaf_flush_state_t fl_state_reg, fl_state_next;
  logic [TAW-1:0] fl_idx_reg, fl_idx_next;
  logic fl_wr, fl_done, fl_rd_en;
  logic [W-1:0] rd_entry, mem_wr_data;
  logic mem_wr_en;
  logic [TAW-1:0] mem_wr_addr;
  logic ent_valid, ent_onehot, ent_group, ent_match;
  logic [NPORTS-1:0] ent_ports;

  logic [NPORTS-1:0] link_prev_reg;
  logic [35:0] age_cnt_reg, age_cnt_next, age_target;
  logic lc_fast_reg, lc_fast_next, age_tick_reg, age_tick_next, age_all_reg, age_all_next;
  logic link_loss, age_on;

  logic frm_done_reg, frm_drop_reg, frm_drop_next;
  logic tx_pause_reg, rx_pause_reg, backoff_reg;
  logic drop_fc, drop_len, drop_size;

  // Bus handshakes
  assign awready = !aw_got_reg && !bvalid_reg;
  assign wready = !w_got_reg && !bvalid_reg;
  assign arready = !rvalid_reg;
  assign bvalid = bvalid_reg;
  assign bresp = bresp_reg;
  assign rvalid = rvalid_reg;
  assign rresp = rresp_reg;
  assign rdata = rdata_reg;
  assign wr_fire = aw_got_reg && w_got_reg && !bvalid_reg;
  assign wr_idx = aw_addr_reg[7:2];
  assign rd_idx = araddr[7:2];

  // Register file and bus slave
  always_comb begin
    ctrl_a_next = ctrl_a_reg;
    ctrl_b_next = ctrl_b_reg;
    aw_got_next = aw_got_reg;
    aw_addr_next = aw_addr_reg;
    w_got_next = w_got_reg;
    w_data_next = w_data_reg;
    w_lane_next = w_lane_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    rvalid_next = rvalid_reg;
    rresp_next = rresp_reg;
    rdata_next = rdata_reg;
    strap_cnt_next = strap_cnt_reg;
    strap_done_next = strap_done_reg;
    if (fl_done) begin
      ctrl_a_next[`SGCAF_A_PURGE] = 1'b0;
    end
    if (!strap_done_reg && strap_cnt_reg == `SGCAF_STRAP_WAIT) begin
      ctrl_b_next[`SGCAF_B_TXDIS] = strap_s2_reg;
      ctrl_b_next[`SGCAF_B_RXDIS] = strap_s2_reg;
      strap_done_next = 1'b1;
    end else if (!strap_done_reg) begin
      strap_cnt_next = strap_cnt_reg + 2'h1;
    end
    if (awvalid && awready) begin
      aw_got_next = 1'b1;
      aw_addr_next = awaddr;
    end
    if (wvalid && wready) begin
      w_got_next = 1'b1;
      w_data_next = wdata[7:0];
      w_lane_next = wstrb[0];
    end
    if (bvalid_reg && bready) begin
      bvalid_next = 1'b0;
    end
    if (wr_fire) begin
      aw_got_next = 1'b0;
      w_got_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = `SGCAF_RESP_SLVERR;
      if (wr_idx == `SGCAF_IDX_A) begin
        bresp_next = `SGCAF_RESP_OKAY;
        if (w_lane_reg) begin
          ctrl_a_next = (ctrl_a_next & ~`SGCAF_WMASK_A) | (w_data_reg & `SGCAF_WMASK_A);
          ctrl_a_next[`SGCAF_A_PURGE] = ctrl_a_next[`SGCAF_A_PURGE] | w_data_reg[`SGCAF_A_PURGE];
        end
      end else if (wr_idx == `SGCAF_IDX_B) begin
        bresp_next = `SGCAF_RESP_OKAY;
        if (w_lane_reg) begin
          ctrl_b_next = (ctrl_b_reg & ~`SGCAF_WMASK_B) | (w_data_reg & `SGCAF_WMASK_B);
          strap_done_next = 1'b1;
        end
      end
    end
    if (arvalid && arready) begin
      rvalid_next = 1'b1;
      rresp_next = `SGCAF_RESP_OKAY;
      if (rd_idx == `SGCAF_IDX_A) begin
        rdata_next = {24'h000000, ctrl_a_reg};
      end else if (rd_idx == `SGCAF_IDX_B) begin
        rdata_next = {24'h000000, ctrl_b_reg};
      end else begin
        rdata_next = 32'h00000000;
        rresp_next = `SGCAF_RESP_SLVERR;
      end
    end else if (rvalid_reg && rready) begin
      rvalid_next = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_a_reg <= `SGCAF_RST_A;
      ctrl_b_reg <= `SGCAF_RST_B;
      aw_got_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_got_reg <= 1'b0;
      w_data_reg <= 8'h00;
      w_lane_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= 2'h0;
      rvalid_reg <= 1'b0;
      rresp_reg <= 2'h0;
      rdata_reg <= 32'h00000000;
      strap_cnt_reg <= 2'h0;
      strap_done_reg <= 1'b0;
      strap_s1_reg <= 1'b0;
      strap_s2_reg <= 1'b0;
    end else if (ce) begin
      ctrl_a_reg <= ctrl_a_next;
      ctrl_b_reg <= ctrl_b_next;
      aw_got_reg <= aw_got_next;
      aw_addr_reg <= aw_addr_next;
      w_got_reg <= w_got_next;
      w_data_reg <= w_data_next;
      w_lane_reg <= w_lane_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      rvalid_reg <= rvalid_next;
      rresp_reg <= rresp_next;
      rdata_reg <= rdata_next;
      strap_cnt_reg <= strap_cnt_next;
      strap_done_reg <= strap_done_next;
      strap_s1_reg <= strap_pause_dis;
      strap_s2_reg <= strap_s1_reg;
    end
  end

  // Static table purge walk
  assign ent_valid = rd_entry[W-1];
  assign ent_ports = rd_entry[48 +: NPORTS];
  assign ent_onehot = (ent_ports != '0) && ((ent_ports & (ent_ports - NPORTS'(1))) == '0);
  assign ent_group = rd_entry[`SGCAF_MAC_GROUP_BIT];
  assign ent_match = ent_valid && ent_onehot && !ent_group && ((ent_ports & learn_dis) != '0);
  assign tbl_wr_ready = !fl_wr;
  assign mem_wr_en = fl_wr || (tbl_wr_valid && tbl_wr_ready);
  assign mem_wr_addr = fl_wr ? fl_idx_reg : tbl_wr_addr;
  assign mem_wr_data = fl_wr ? {1'b0, rd_entry[W-2:0]} : {tbl_wr_entry_valid, tbl_wr_ports, tbl_wr_mac};

  always_comb begin
    fl_state_next = fl_state_reg;
    fl_idx_next = fl_idx_reg;
    fl_wr = 1'b0;
    fl_done = 1'b0;
    fl_rd_en = 1'b0;
    case (fl_state_reg)
      SGCAF_FL_IDLE: begin
        if (ctrl_a_reg[`SGCAF_A_PURGE]) begin
          fl_state_next = SGCAF_FL_READ;
          fl_idx_next = '0;
        end
      end
      SGCAF_FL_READ: begin
        fl_rd_en = 1'b1;
        fl_state_next = SGCAF_FL_CHECK;
      end
      SGCAF_FL_CHECK: begin
        fl_wr = ent_match;
        if (fl_idx_reg == TAW'(DEPTH - 1)) begin
          fl_done = 1'b1;
          fl_state_next = SGCAF_FL_IDLE;
        end else begin
          fl_idx_next = fl_idx_reg + TAW'(1);
          fl_state_next = SGCAF_FL_READ;
        end
      end
      default: begin
        fl_state_next = SGCAF_FL_IDLE;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fl_state_reg <= SGCAF_FL_IDLE;
      fl_idx_reg <= '0;
    end else if (ce) begin
      fl_state_reg <= fl_state_next;
      fl_idx_reg <= fl_idx_next;
    end
  end

  sgcaf_static_mem #(.W(W), .DEPTH(DEPTH), .AW(TAW)) u_table (
    .clk(aclk),
    .ce(ce),
    .wr_en(mem_wr_en),
    .wr_addr(mem_wr_addr),
    .wr_data(mem_wr_data),
    .rd_en(fl_rd_en),
    .rd_addr(fl_idx_reg),
    .rd_data(rd_entry)
  );

  // Aging timer
  assign link_loss = (link_prev_reg & ~link_up) != '0;
  assign age_on = ctrl_b_reg[`SGCAF_B_AGE];
  assign age_target = (ctrl_b_reg[`SGCAF_B_FAST] || lc_fast_reg) ? FAST_AGE_CYC : NORMAL_AGE_CYC;
  assign age_tick = age_tick_reg;
  assign age_all = age_all_reg;

  always_comb begin
    age_cnt_next = age_cnt_reg + 36'h1;
    lc_fast_next = lc_fast_reg;
    age_tick_next = 1'b0;
    age_all_next = 1'b0;
    if (!age_on) begin
      age_cnt_next = 36'h0;
      lc_fast_next = 1'b0;
    end else if (age_cnt_reg >= age_target - 36'h1) begin
      age_cnt_next = 36'h0;
      age_tick_next = 1'b1;
      age_all_next = lc_fast_reg;
      lc_fast_next = 1'b0;
    end
    if (age_on && ctrl_a_reg[`SGCAF_A_LCAGE] && link_loss) begin
      lc_fast_next = 1'b1;
      age_cnt_next = 36'h0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      link_prev_reg <= '0;
      age_cnt_reg <= 36'h0;
      lc_fast_reg <= 1'b0;
      age_tick_reg <= 1'b0;
      age_all_reg <= 1'b0;
    end else if (ce) begin
      link_prev_reg <= link_up;
      age_cnt_reg <= age_cnt_next;
      lc_fast_reg <= lc_fast_next;
      age_tick_reg <= age_tick_next;
      age_all_reg <= age_all_next;
    end
  end

  // Frame filters and port controls
  assign drop_fc = ctrl_a_reg[`SGCAF_A_COMPL] ?
    (frm_type_len == `SGCAF_PAUSE_TYPE || frm_da == `SGCAF_PAUSE_DA) : frm_is_pause;
  assign drop_len = ctrl_b_reg[`SGCAF_B_LENCHK] && frm_type_len < `SGCAF_LEN_TYPE_LIM &&
    frm_type_len != frm_payload_len;
  assign drop_size = frm_byte_len > (ctrl_b_reg[`SGCAF_B_BIG] ? `SGCAF_BIG_FRAME_MAX : STD_FRAME_MAX);
  assign frm_drop_next = frm_valid && (drop_fc || drop_len || drop_size);
  assign frm_done = frm_done_reg;
  assign frm_drop = frm_drop_reg;
  assign tx_pause_en = tx_pause_reg;
  assign rx_pause_en = rx_pause_reg;
  assign aggr_backoff = backoff_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      frm_done_reg <= 1'b0;
      frm_drop_reg <= 1'b0;
      tx_pause_reg <= 1'b0;
      rx_pause_reg <= 1'b0;
      backoff_reg <= 1'b0;
    end else if (ce) begin
      frm_done_reg <= frm_valid;
      frm_drop_reg <= frm_drop_next;
      tx_pause_reg <= an_tx_pause && !ctrl_b_reg[`SGCAF_B_TXDIS];
      rx_pause_reg <= an_rx_pause && !ctrl_b_reg[`SGCAF_B_RXDIS];
      backoff_reg <= ctrl_b_reg[`SGCAF_B_BACKOFF];
    end
  end

  // Checks
  chk_purge_start: assert property (@(posedge aclk) disable iff (!aresetn)
    (ce && ctrl_a_reg[`SGCAF_A_PURGE] && fl_state_reg == SGCAF_FL_IDLE) |=> (fl_state_reg == SGCAF_FL_READ))
    else $error("Purge walk did not start");
  chk_purge_match: assert property (@(posedge aclk) disable iff (!aresetn)
    (fl_wr) |-> (rd_entry[W-1] && $onehot(rd_entry[48 +: NPORTS]) && !rd_entry[`SGCAF_MAC_GROUP_BIT] &&
    (rd_entry[48 +: NPORTS] & learn_dis) != '0))
    else $error("Purge removed an unmatched entry");
  chk_purge_entry: assert property (@(posedge aclk) disable iff (!aresetn)
    (fl_state_reg == SGCAF_FL_CHECK && ent_match) |-> (mem_wr_en && mem_wr_addr == fl_idx_reg && !mem_wr_data[W-1]))
    else $error("Matched entry not cleared");
  chk_purge_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    (ce && fl_done && !wr_fire) |=> !ctrl_a_reg[`SGCAF_A_PURGE])
    else $error("Purge bit did not clear");
  chk_drop_compl: assert property (@(posedge aclk) disable iff (!aresetn)
    (ce && frm_valid && ctrl_a_reg[`SGCAF_A_COMPL] && frm_da == `SGCAF_PAUSE_DA) |=> frm_drop)
    else $error("Compliance frame not dropped");
  chk_drop_pause: assert property (@(posedge aclk) disable iff (!aresetn)
    (ce && frm_valid && !ctrl_a_reg[`SGCAF_A_COMPL] && !drop_len && !drop_size) |=> (frm_drop == $past(frm_is_pause)))
    else $error("Flow-control drop wrong");
  chk_fast_bound: assert property (@(posedge aclk) disable iff (!aresetn)
    (lc_fast_reg) |-> (age_cnt_reg < FAST_AGE_CYC))
    else $error("Fast age cycle overran");
  chk_fast_end: assert property (@(posedge aclk) disable iff (!aresetn)
    (ce && age_on && lc_fast_reg && age_cnt_reg >= FAST_AGE_CYC - 36'h1 && !link_loss) |=> (age_tick && age_all && !lc_fast_reg))
    else $error("Link-loss age cycle wrong");
  chk_tx_pause: assert property (@(posedge aclk) disable iff (!aresetn)
    (ce) |=> (tx_pause_en == ($past(an_tx_pause) && !$past(ctrl_b_reg[`SGCAF_B_TXDIS]))))
    else $error("Transmit pause mismatch");
  chk_strap_load: assert property (@(posedge aclk) disable iff (!aresetn)
    (ce && !strap_done_reg && strap_cnt_reg == `SGCAF_STRAP_WAIT && !wr_fire) |=>
    (ctrl_b_reg[`SGCAF_B_TXDIS] == $past(strap_s2_reg) && ctrl_b_reg[`SGCAF_B_RXDIS] == $past(strap_s2_reg)))
    else $error("Strap not loaded");
  chk_len_drop: assert property (@(posedge aclk) disable iff (!aresetn)
    (ce && frm_valid && ctrl_b_reg[`SGCAF_B_LENCHK] && frm_type_len < `SGCAF_LEN_TYPE_LIM &&
     frm_type_len != frm_payload_len) |=> frm_drop)
    else $error("Length mismatch not dropped");
  chk_age_off: assert property (@(posedge aclk) disable iff (!aresetn)
    (ce && !age_on) |=> (!age_tick && age_cnt_reg == 36'h0))
    else $error("Aging ran while disabled");
endmodule : sgcaf_global_ctrl
`default_nettype wire

/* File: hdl/sgcaf_pkg.sv */
// Types shared by the global control bank
`default_nettype none
package sgcaf_pkg;
  typedef enum logic [2:0] {
    SGCAF_FL_IDLE = 3'b001,
    SGCAF_FL_READ = 3'b010,
    SGCAF_FL_CHECK = 3'b100
  } sgcaf_flush_state_t;
endpackage : sgcaf_pkg
`default_nettype wire

/* File: hdl/sgcaf_static_mem.sv */
// Static address table storage with registered read data
`default_nettype none
module sgcaf_static_mem #(
  parameter int W = 54,
  parameter int DEPTH = 16,
  parameter int AW = 4
) (
  // Clock and enable
  input wire logic clk,
  input wire logic ce,
  // Write port
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [W-1:0] wr_data,
  // Read port
  input wire logic rd_en,
  input wire logic [AW-1:0] rd_addr,
  output logic [W-1:0] rd_data
);
  logic [W-1:0] mem [DEPTH];

  always_ff @(posedge clk) begin
    if (ce && wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    if (ce && rd_en) begin
      rd_data <= mem[rd_addr];
    end
  end
endmodule : sgcaf_static_mem
`default_nettype wire

/* File: sim/tb_top.sv */
// Self-checking bench for the global control bank
`default_nettype none
`define CHK(a, e, m) begin total_checks++; if ((a) !== (e)) begin miscompares++; $display("BAD t=%0t %s", $time, m); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int NORM = 200;
  localparam int FAST = 20;
  logic aclk, aresetn, ce, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb, tbl_wr_addr;
  logic [1:0] bresp, rresp;
  logic strap_pause_dis, an_tx_pause, an_rx_pause, tbl_wr_valid, tbl_wr_ready, tbl_wr_entry_valid;
  logic [4:0] link_up, learn_dis, tbl_wr_ports;
  logic [47:0] tbl_wr_mac, frm_da;
  logic frm_valid, frm_is_pause, frm_done, frm_drop, tx_pause_en, rx_pause_en, aggr_backoff, age_tick, age_all;
  logic [15:0] frm_type_len, frm_payload_len;
  logic [11:0] frm_byte_len;
  logic tick_all, cnt_en;
  int miscompares = 0;
  int total_checks = 0;
  int cyc = 0;
  int last_tick = 0;
  int gap = 0;
  int ticks = 0;
  int low_cnt = 0;

  sgcaf_global_ctrl #(.NORMAL_AGE_CYC(36'(NORM)), .FAST_AGE_CYC(36'(FAST))) uut (
    .aclk, .aresetn, .ce, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid,
    .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .strap_pause_dis, .link_up,
    .learn_dis, .an_tx_pause, .an_rx_pause, .tbl_wr_valid, .tbl_wr_ready, .tbl_wr_addr, .tbl_wr_entry_valid,
    .tbl_wr_ports, .tbl_wr_mac, .frm_valid, .frm_type_len, .frm_da, .frm_payload_len, .frm_byte_len,
    .frm_is_pause, .frm_done, .frm_drop, .tx_pause_en, .rx_pause_en, .aggr_backoff, .age_tick, .age_all
  );

  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  // Cycle count, purge stall count, age tick spacing, timeout
  always @(negedge aclk) begin
    cyc++;
    if (cnt_en && tbl_wr_ready === 1'b0) low_cnt++;
    if (age_tick === 1'b1) begin
      gap = cyc - last_tick;
      last_tick = cyc;
      tick_all = age_all;
      ticks++;
    end
    if (cyc > 20000) begin
      miscompares++;
      $display("BAD t=%0t timeout", $time);
      conclude();
    end
  end

  task automatic conclude;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : conclude

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ta, tw, da, dw, b;
    logic [1:0] r;
    da = 1'b0;
    dw = 1'b0;
    b = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(da && dw)) begin
      @(negedge aclk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      da = da | ta;
      dw = dw | tw;
    end
    while (!b) begin
      @(negedge aclk);
      b = bvalid;
      r = bresp;
      @(posedge aclk);
    end
    bready <= 1'b0;
    `CHK(r, er, "write response")
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic t, v;
    t = 1'b0;
    v = 1'b0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!t) begin
      @(negedge aclk);
      t = arready;
      @(posedge aclk);
    end
    arvalid <= 1'b0;
    while (!v) begin
      @(negedge aclk);
      v = rvalid;
      d = rdata;
      r = rresp;
      @(posedge aclk);
    end
    rready <= 1'b0;
  endtask : rd

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    `CHK(d, e, "read data")
    `CHK(r, er, "read response")
  endtask : rd_chk

  function automatic logic exp_drop(input logic [7:0] ca, input logic [7:0] cb, input logic [15:0] t,
                                    input logic [15:0] pl, input logic [47:0] da, input logic [11:0] bl,
                                    input logic ip);
    logic fl, lc, sz;
    fl = ca[1] ? (t == 16'h8808 || da == 48'h0180c2000001) : ip;
    lc = cb[3] && t < 16'h05dc && t != pl;
    sz = bl > (cb[6] ? 12'h800 : 12'h600);
    return fl || lc || sz;
  endfunction : exp_drop

  task automatic frame(input logic [7:0] ca, input logic [7:0] cb);
    logic [15:0] t, pl;
    logic [47:0] da;
    logic [11:0] bl;
    logic ip;
    t = ($urandom_range(2) == 0) ? 16'h8808 : 16'($urandom_range(16'h0700));
    da = ($urandom_range(1) == 0) ? 48'h0180c2000001 : 48'({$urandom(), $urandom()});
    pl = ($urandom_range(1) == 0) ? t : 16'($urandom_range(16'h0700));
    bl = 12'h5ff + 12'($urandom_range(2)) + (($urandom_range(1) == 0) ? 12'h200 : 12'h000);
    ip = 1'($urandom_range(1));
    @(posedge aclk);
    frm_type_len <= t;
    frm_da <= da;
    frm_payload_len <= pl;
    frm_byte_len <= bl;
    frm_is_pause <= ip;
    frm_valid <= 1'b1;
    @(posedge aclk);
    frm_valid <= 1'b0;
    @(negedge aclk);
    `CHK(frm_done, 1'b1, "frame answer")
    `CHK(frm_drop, exp_drop(ca, cb, t, pl, da, bl, ip), "frame drop")
  endtask : frame

  task automatic tbl_load(input logic [3:0] a, input logic v, input logic [4:0] p, input logic [47:0] m);
    logic t;
    t = 1'b0;
    @(posedge aclk);
    tbl_wr_addr <= a;
    tbl_wr_entry_valid <= v;
    tbl_wr_ports <= p;
    tbl_wr_mac <= m;
    tbl_wr_valid <= 1'b1;
    while (!t) begin
      @(negedge aclk);
      t = tbl_wr_ready;
      @(posedge aclk);
    end
    tbl_wr_valid <= 1'b0;
  endtask : tbl_load

  task automatic purge(input int exp_cnt);
    logic [31:0] d;
    logic [1:0] r;
    int n;
    low_cnt = 0;
    cnt_en = 1'b1;
    wr(8'h08, 32'h10, 2'h0);
    rd(8'h08, d, r);
    `CHK(d[4], 1'b1, "purge busy")
    n = 0;
    while (d[4] && n < 40) begin
      rd(8'h08, d, r);
      n++;
    end
    cnt_en = 1'b0;
    `CHK(d, 32'h0c, "purge self clear")
    `CHK(low_cnt, exp_cnt, "purged entry count")
  endtask : purge

  task automatic wait_tick;
    int n;
    n = ticks;
    while (ticks == n) @(negedge aclk);
  endtask : wait_tick

  function automatic logic near(input int g, input int n);
    return g >= n - 2 && g <= n + 2;
  endfunction : near

  initial begin
    logic [31:0] d;
    logic [7:0] ca, cb;
    logic [4:0] p;
    logic [47:0] m;
    logic v;
    int e, t0, n;
    void'($urandom(35));
    {ce, aresetn, strap_pause_dis, an_tx_pause, an_rx_pause, cnt_en} = 6'b101000;
    {awvalid, wvalid, bready, arvalid, rready, tbl_wr_valid, frm_valid} = '0;
    {awaddr, araddr, wdata, wstrb} = {16'h0, 32'h0, 4'hf};
    {tbl_wr_addr, tbl_wr_entry_valid, tbl_wr_ports, tbl_wr_mac, learn_dis} = '0;
    {frm_type_len, frm_da, frm_payload_len, frm_byte_len, frm_is_pause} = '0;
    link_up = 5'h1f;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (8) @(posedge aclk);
    rd_chk(8'h08, 32'h0c, 2'h0);
    rd_chk(8'h0c, 32'h34, 2'h0);
    wr(8'h0c, 32'h24, 2'h0);
    rd_chk(8'h0c, 32'h24, 2'h0);
    rd_chk(8'h10, 32'h0, 2'h2);
    wr(8'h10, 32'hff, 2'h2);
    wstrb <= 4'he;
    wr(8'h0c, 32'h00, 2'h0);
    wstrb <= 4'hf;
    rd_chk(8'h0c, 32'h24, 2'h0);
    for (int i = 0; i < 6; i++) begin
      d = $urandom();
      wr(8'h0c, d, 2'h0);
      wr(8'h08, d & 32'hef, 2'h0);
      rd_chk(8'h0c, {25'h0, d[6:0]}, 2'h0);
      rd_chk(8'h08, {30'h3, d[1:0]}, 2'h0);
      @(posedge aclk);
      an_tx_pause <= 1'($urandom_range(1));
      an_rx_pause <= 1'($urandom_range(1));
      repeat (2) @(posedge aclk);
      @(negedge aclk);
      `CHK(tx_pause_en, an_tx_pause & ~d[5], "tx pause")
      `CHK(rx_pause_en, an_rx_pause & ~d[4], "rx pause")
      `CHK(aggr_backoff, d[0], "back-off")
    end
    $display("test registers done");
    for (int i = 0; i < 8; i++) begin
      ca = {6'h0, i[0], 1'b0};
      cb = {1'b0, i[1], 2'b00, i[2], 3'b100};
      wr(8'h08, 32'(ca), 2'h0);
      wr(8'h0c, 32'(cb), 2'h0);
      repeat (6) frame(ca, cb);
    end
    $display("test frames done");
    @(posedge aclk);
    learn_dis <= 5'h01 | 5'($urandom_range(31));
    e = 3;
    for (int i = 0; i < 3; i++) tbl_load(4'(i), 1'b1, 5'h01, 48'h0012_3456_7890 + 48'(i));
    for (int i = 3; i < 16; i++) begin
      v = $urandom_range(3) != 0;
      p = ($urandom_range(2) == 0) ? 5'h03 : 5'(1 << $urandom_range(4));
      m = 48'({$urandom(), $urandom()});
      if (v && $onehot(p) && !m[40] && |(p & learn_dis)) e++;
      tbl_load(4'(i), v, p, m);
    end
    purge(e);
    purge(0);
    $display("test purge done");
    wr(8'h08, 32'h01, 2'h0);
    wr(8'h0c, 32'h04, 2'h0);
    wait_tick();
    wait_tick();
    `CHK(near(gap, NORM), 1'b1, "normal period")
    `CHK(tick_all, 1'b0, "normal tick")
    wr(8'h0c, 32'h06, 2'h0);
    wait_tick();
    wait_tick();
    `CHK(near(gap, FAST), 1'b1, "fast period")
    wr(8'h0c, 32'h04, 2'h0);
    wait_tick();
    @(posedge aclk);
    link_up <= 5'h1b;
    t0 = cyc;
    wait_tick();
    `CHK(cyc - t0 <= FAST + 3, 1'b1, "link loss fast age")
    `CHK(tick_all, 1'b1, "age all")
    @(posedge aclk);
    link_up <= 5'h1f;
    wait_tick();
    `CHK(near(gap, NORM), 1'b1, "back to normal")
    `CHK(tick_all, 1'b0, "single fast cycle")
    wr(8'h0c, 32'h00, 2'h0);
    repeat (4) @(posedge aclk);
    n = ticks;
    repeat (2 * NORM) @(negedge aclk);
    `CHK(ticks, n, "aging off")
    $display("test aging done");
    @(posedge aclk);
    an_tx_pause <= 1'b0;
    repeat (2) @(posedge aclk);
    ce <= 1'b0;
    an_tx_pause <= 1'b1;
    repeat (3) @(posedge aclk);
    @(negedge aclk);
    `CHK(tx_pause_en, 1'b0, "frozen by enable")
    @(posedge aclk);
    ce <= 1'b1;
    repeat (2) @(posedge aclk);
    @(negedge aclk);
    `CHK(tx_pause_en, 1'b1, "resumed after enable")
    $display("test enable done");
    conclude();
  end
endmodule : tb_top
`default_nettype wire
